/* sim/mfm_host_model.sv */
// Purpose: Host side model, AHB-Lite master
// Assumes: Single word transfers, any wait states
// Notes: Signals change just after a rising edge
`timescale 1ns/1ps
module mfm_host_model (
	input wire logic clk_sys, // System clock
	input wire logic hreadyout, // Slave ready
	input wire logic [31:0] hrdata, // Read data
	output logic [31:0] haddr, // Address
	output logic [1:0] htrans, // Transfer type
	output logic hwrite, // Write
	output logic [31:0] hwdata // Write data
);
	initial begin
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_sys);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench of the fault and mode manager
// Assumes: Shortened counts through parameters
// Notes: Host model makes all bus cycles
`timescale 1ns/1ps
module tb;
	import mfm_pkg::*;
	localparam int RC = 30;
	logic clk_sys, resetn, sleepInN, vccLow, overTemp, tempCooled;
	logic outOverVolt, sleepBrakeOc, stallRaw, hreadyout, hwrite;
	logic faultOutNOe, activeMode, ce, hresp, faultOutN, stallDetect;
	logic [1:0] ocLimitHigh, ocLimitLow, ctrlIn, hsGate, lsGate, htrans;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [7:0] ra[4], rampLevel;
	logic [31:0] rw[4], re[4];
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	mfm_top #(.INRUSH_BASE_CYCLES(20), .RETRY_CYCLES(RC),
		.WAKE_CYCLES(10), .TURNOFF_CYCLES(10)) dut_u (
		.clk_sys(clk_sys), .resetn(resetn), .clkEn(ce), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .sleepInN(sleepInN), .vccLow(vccLow),
		.ocLimitHigh(ocLimitHigh), .ocLimitLow(ocLimitLow),
		.overTemp(overTemp), .tempCooled(tempCooled),
		.outOverVolt(outOverVolt), .sleepBrakeOc(sleepBrakeOc),
		.stallRaw(stallRaw), .ctrlIn(ctrlIn), .hsGate(hsGate),
		.lsGate(lsGate), .faultOutN(faultOutN), .faultOutNOe(faultOutNOe),
		.activeMode(activeMode), .stallDetect(stallDetect),
		.rampLevel(rampLevel));
	mfm_host_model host_u (.clk_sys(clk_sys), .hreadyout(hreadyout),
		.hrdata(hrdata), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic wrap_up;
		$display("checks=%0d fails=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 15000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'b1, {24'h0, a}, d, rdv);
		wc(2);
	endtask
	task automatic rd(input logic [7:0] a);
		host_u.xfer(1'b0, {24'h0, a}, 32'h0, rdv);
	endtask
	initial begin
		ra = '{ADDR_INRUSH, ADDR_TARGET, 8'h10, ADDR_CONFIG};
		rw = '{32'hFFFF, 32'h1FF, 32'hFFFFFFFF, 32'h80};
		re = '{32'hFFFF, 32'hFF, 32'h0, 32'h80};
		{resetn, vccLow, overTemp, tempCooled, outOverVolt} = 5'h0;
		{sleepInN, sleepBrakeOc, stallRaw} = 3'h0;
		{ocLimitHigh, ocLimitLow, ctrlIn} = 6'h0;
		ce = 1'b1;
		wc(6);
		resetn <= 1'b1;
		wc(1);
		chk(faultOutNOe, 1'b0);
		chk({hresp, faultOutN}, 2'h0);
		rd(ADDR_CONFIG);
		chk(rdv, 32'h40);
		rd(ADDR_INRUSH);
		chk(rdv, {16'h0, INRUSH_RESET});
		rd(ADDR_STATUS);
		chk(rdv, 32'h100);
		sleepInN <= 1'b1;
		wc(20);
		wr(ADDR_CONFIG, 32'h82);
		chk(activeMode, 1'b1);
		rd(ADDR_STATUS);
		chk(rdv, 32'h202);
		for (int i = 0; i < 4; i++) begin
			wr(ra[i], rw[i]);
			rd(ra[i]);
			chk(rdv, re[i]);
		end
		ctrlIn <= 2'h1;
		ocLimitHigh <= 2'h1;
		wc(35);
		chk({hsGate, lsGate, faultOutNOe}, 5'h1);
		ocLimitHigh <= 2'h0;
		wc(50);
		chk(faultOutNOe, 1'b1);
		rd(ADDR_STATUS);
		chk(rdv & 32'h96, 32'h92);
		wr(ADDR_CONFIG, 32'h82);
		wc(3);
		chk(faultOutNOe, 1'b0);
		wr(ADDR_CONFIG, 32'h81);
		ocLimitLow <= 2'h2;
		wc(35);
		chk(faultOutNOe, 1'b1);
		ocLimitLow <= 2'h0;
		wc(RC + 10);
		chk(faultOutNOe, 1'b0);
		wr(ADDR_CONFIG, 32'h86);
		overTemp <= 1'b1;
		wc(6);
		chk(faultOutNOe, 1'b1);
		overTemp <= 1'b0;
		tempCooled <= 1'b1;
		wc(6);
		chk(faultOutNOe, 1'b0);
		rd(ADDR_STATUS);
		chk(rdv & 32'h84, 32'h04);
		wr(ADDR_CONFIG, 32'h82);
		tempCooled <= 1'b0;
		overTemp <= 1'b1;
		wc(6);
		overTemp <= 1'b0;
		tempCooled <= 1'b1;
		wc(10);
		chk(faultOutNOe, 1'b1);
		wr(ADDR_CONFIG, 32'h82);
		wc(3);
		chk(faultOutNOe, 1'b0);
		ctrlIn <= 2'h0;
		wr(ADDR_INRUSH, 32'h1);
		wr(ADDR_TARGET, 32'h1);
		wr(ADDR_CONFIG, 32'hB0);
		ctrlIn <= 2'h2;
		stallRaw <= 1'b1;
		wc(10);
		chk(rampLevel, 8'h00);
		chk(stallDetect, 1'b0);
		wc(INRUSH_STEP_CYC);
		chk(stallDetect, 1'b0);
		wc(40);
		chk({stallDetect, rampLevel}, 9'h101);
		ctrlIn <= 2'h0;
		wc(10);
		chk(rampLevel, 8'h01);
		wc(INRUSH_STEP_CYC + 40);
		chk(rampLevel, 8'h00);
		sleepInN <= 1'b0;
		wc(20);
		chk(activeMode, 1'b0);
		outOverVolt <= 1'b1;
		wc(6);
		chk(lsGate, 2'h0);
		resetn <= 1'b0;
		wc(2);
		resetn <= 1'b1;
		wc(6);
		chk(lsGate, 2'h3);
		sleepBrakeOc <= 1'b1;
		wc(6);
		chk(lsGate, 2'h0);
		ce <= 1'b0;
		vccLow <= 1'b1;
		wc(6);
		chk(faultOutNOe, 1'b0);
		ce <= 1'b1;
		wc(6);
		chk(faultOutNOe, 1'b1);
		wrap_up();
	end
endmodule

/* verilog/mfm_inrush_timer.sv */
// Purpose: Inrush window timer, base time plus code steps
// Assumes: Code taken on the start pulse
// Notes: Window is BASE_CYCLES plus code times STEP_CYCLES
`timescale 1ns/1ps
module mfm_inrush_timer #(
	parameter int BASE_CYCLES = mfm_pkg::INRUSH_BASE_CYC, // Base length
	parameter int STEP_CYCLES = mfm_pkg::INRUSH_STEP_CYC // One code step
) (
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Async reset, active low
	mfm_timer_if.timer tIf // Control side
);
	import mfm_pkg::*;

	logic [CNT_W-1:0] cnt_reg;
	logic [23:0] left_reg;
	logic inBase_reg;
	logic busy_reg;
	logic tick_reg;

	assign tIf.busy = busy_reg;
	assign tIf.tick = tick_reg;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
			left_reg <= '0;
			inBase_reg <= 1'b0;
			busy_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else if (tIf.clkEn) begin
			tick_reg <= 1'b0;
			if (tIf.clear) begin
				busy_reg <= 1'b0;
				inBase_reg <= 1'b0;
			end else if (tIf.start) begin
				busy_reg <= 1'b1;
				inBase_reg <= 1'b1;
				cnt_reg <= CNT_W'(BASE_CYCLES - 1);
				left_reg <= tIf.code;
			end else if (busy_reg) begin
				if (cnt_reg != '0) begin
					cnt_reg <= cnt_reg - 1'b1;
				end else if (inBase_reg) begin
					inBase_reg <= 1'b0;
					cnt_reg <= CNT_W'(STEP_CYCLES - 1);
					busy_reg <= (left_reg != '0);
				end else begin
					tick_reg <= 1'b1;
					cnt_reg <= CNT_W'(STEP_CYCLES - 1);
					left_reg <= left_reg - 1'b1;
					busy_reg <= (left_reg != 24'h000001);
				end
			end
		end
	end
endmodule

/* verilog/mfm_pkg.sv */
// Purpose: Shared constants and types for the motor fault and mode manager
// Assumes: clk_sys at 25 MHz; registers reached over AHB-Lite
// Notes: Byte addresses, one 32-bit word per register
// Contract
// - Stall reporting blanked during inrush window
// - Plain window is base plus code steps
// - Soft-start window is setting times target
// - Ramp up to target, down to zero
// - Persistent current limit shuts bridge, flags fault
// - Overcurrent select: latch-off or auto retry
// - Retry holds off for retry time, repeats
// - Latch-off holds until clear-fault command
// - High and low side limits detected separately; the code ORs all four limit inputs into one deglitch counter
// - Over-temperature shuts bridge, flags fault
// - Auto thermal resumes on cool, flag stays
// - Latched thermal resumes only on clear
// - Undervoltage resets logic, disables bridge
// - Power-on flag low until clear-fault
// - Output overvoltage brakes both low sides
// - Brake enable set at reset, kept through sleep
// - Sleep brake overcurrent turns low sides off
// - Fault pin released after power-up, low on fault
// - Active needs supply, wake done, output enable
// - Sleep pin low for turn-off time sleeps
package mfm_pkg;
	localparam int CLK_NS = 40;
	localparam int CNT_W = 24;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_INRUSH = 8'h08;
	localparam logic [7:0] ADDR_TARGET = 8'h0C;
	// Status word fields
	localparam int ST_POWER = 1;
	localparam int ST_THERM = 2;
	localparam int ST_OVP = 3;
	localparam int ST_OC = 4;
	localparam int ST_STALL = 5;
	localparam int ST_FAULT = 7;
	localparam int ST_SLEEP = 8;
	localparam int ST_ACTIVE = 9;
	// Config word fields
	localparam int CFG_OCSEL = 0;
	localparam int CFG_CLR = 1;
	localparam int CFG_THSEL = 2;
	localparam int CFG_MODE = 3;
	localparam int CFG_SOFT = 5;
	localparam int CFG_OVP = 6;
	localparam int CFG_OUTEN = 7;
	localparam logic [15:0] INRUSH_RESET = 16'h260C;
	localparam logic [7:0] TARGET_RESET = 8'h00;
	localparam logic OVP_EN_RESET = 1'b1;
	localparam logic OUT_EN_RESET = 1'b0;
	// Inrush window: 5 ms at code 0, 6.7 s at full scale
	localparam longint INRUSH_MIN_NS = 64'd5000000;
	localparam longint INRUSH_MAX_NS = 64'd6700000000;
	localparam longint INRUSH_STEP_NS =
		(INRUSH_MAX_NS - INRUSH_MIN_NS) / 64'd65535;
	localparam int INRUSH_BASE_CYC = int'(INRUSH_MIN_NS / CLK_NS);
	localparam int INRUSH_STEP_CYC = int'(INRUSH_STEP_NS / CLK_NS);
	localparam int OCP_DEGLITCH_NS = 1000;
	localparam int OCP_CYC = (OCP_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RETRY_NS = 4000000;
	localparam int RETRY_CYC = (RETRY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_NS = 1000000;
	localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TURNOFF_NS = 1000000;
	localparam int TURNOFF_CYC = (TURNOFF_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {MODE_SLEEP, MODE_WAKE, MODE_ON} mfm_mode_type;
	typedef enum logic [1:0] {
		RAMP_IDLE, RAMP_UP, RAMP_RUN, RAMP_DOWN
	} mfm_ramp_type;
	typedef enum logic [2:0] {
		REG_NONE, REG_STATUS, REG_CONFIG, REG_INRUSH, REG_TARGET
	} mfm_reg_type;
endpackage

/* verilog/mfm_timer_if.sv */
// Purpose: Link between the manager and its inrush window timer
// Assumes: One clock domain
// Notes: Start is a one-cycle pulse; tick marks each step
`timescale 1ns/1ps
interface mfm_timer_if;
	logic clkEn;
	logic clear;
	logic start;
	logic [23:0] code;
	logic busy;
	logic tick;
	modport ctrl(output clkEn, clear, start, code, input busy, tick);
	modport timer(input clkEn, clear, start, code, output busy, tick);
endinterface

/* verilog/mfm_top.sv */
// Purpose: Fault protection and operating mode manager of the H-bridge
// Assumes: Analog comparators give levels; AHB-Lite master keeps clkEn high
// Notes: Fault pin is open drain, enable high pulls it low
`timescale 1ns/1ps
module mfm_top #(
	parameter int INRUSH_BASE_CYCLES = mfm_pkg::INRUSH_BASE_CYC, // Base
	parameter int RETRY_CYCLES = mfm_pkg::RETRY_CYC, // Retry hold
	parameter int WAKE_CYCLES = mfm_pkg::WAKE_CYC, // Wake time
	parameter int TURNOFF_CYCLES = mfm_pkg::TURNOFF_CYC // Sleep entry
) (
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic clkEn, // Clock enable
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [2:0] hsize, // Size, word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic [31:0] hrdata, // Read data
	output logic hresp, // Response, always OKAY
	input wire logic sleepInN, // Sleep pin, low sleeps
	input wire logic vccLow, // Logic supply undervoltage
	input wire logic [1:0] ocLimitHigh, // High-side current limit
	input wire logic [1:0] ocLimitLow, // Low-side current limit
	input wire logic overTemp, // Die over temperature
	input wire logic tempCooled, // Below threshold minus hysteresis
	input wire logic outOverVolt, // Output above motor supply
	input wire logic sleepBrakeOc, // High current while braking
	input wire logic stallRaw, // Raw stall indication
	input wire logic [1:0] ctrlIn, // Drive inputs
	output logic [1:0] hsGate, // High-side FET on
	output logic [1:0] lsGate, // Low-side FET on
	output logic faultOutN, // Fault pin level when driven
	output logic faultOutNOe, // Fault pin pull-down enable
	output logic activeMode, // Active mode
	output logic stallDetect, // Stall flag
	output logic [7:0] rampLevel // Soft ramp level
);
	import mfm_pkg::*;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	function automatic mfm_reg_type regSel(input logic [31:0] addr);
		regSel = REG_NONE;
		if (addr[31:8] == 24'h000000) begin
			unique case (addr[7:0])
				ADDR_STATUS: regSel = REG_STATUS;
				ADDR_CONFIG: regSel = REG_CONFIG;
				ADDR_INRUSH: regSel = REG_INRUSH;
				ADDR_TARGET: regSel = REG_TARGET;
				default: regSel = REG_NONE;
			endcase
		end
	endfunction

	mfm_timer_if tIf();

	logic [12:0] syncMeta_reg;
	logic [12:0] syncIn_reg;
	logic sleepPinN;
	logic uvlo;
	logic ocAny;
	logic hotS;
	logic coolS;
	logic ovS;
	logic sleepOcS;
	logic stallS;
	logic [1:0] ctrlS;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			syncMeta_reg <= 13'h0000;
			syncIn_reg <= 13'h0000;
		end else if (clkEn) begin
			syncMeta_reg <= {sleepInN, vccLow, ocLimitHigh, ocLimitLow,
				overTemp, tempCooled, outOverVolt, sleepBrakeOc, stallRaw,
				ctrlIn};
			syncIn_reg <= syncMeta_reg;
		end
	end

	assign sleepPinN = syncIn_reg[12];
	assign uvlo = syncIn_reg[11];
	assign ocAny = |syncIn_reg[10:7];
	assign hotS = syncIn_reg[6];
	assign coolS = syncIn_reg[5];
	assign ovS = syncIn_reg[4];
	assign sleepOcS = syncIn_reg[3];
	assign stallS = syncIn_reg[2];
	assign ctrlS = syncIn_reg[1:0];

	// Operating mode from the sleep pin
	mfm_mode_type mode_reg;
	logic [CNT_W-1:0] pinCnt_reg;
	logic logicClr;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= MODE_SLEEP;
			pinCnt_reg <= '0;
		end else if (clkEn) begin
			unique case (mode_reg)
				MODE_SLEEP: begin
					pinCnt_reg <= '0;
					if (sleepPinN && !uvlo) begin
						mode_reg <= MODE_WAKE;
					end
				end
				MODE_WAKE: begin
					if (!sleepPinN || uvlo) begin
						mode_reg <= MODE_SLEEP;
					end else if (pinCnt_reg == CNT_W'(WAKE_CYCLES - 1)) begin
						mode_reg <= MODE_ON;
						pinCnt_reg <= '0;
					end else begin
						pinCnt_reg <= pinCnt_reg + 1'b1;
					end
				end
				MODE_ON: begin
					if (sleepPinN) begin
						pinCnt_reg <= '0;
					end else if (pinCnt_reg == CNT_W'(TURNOFF_CYCLES - 1)) begin
						mode_reg <= MODE_SLEEP;
						pinCnt_reg <= '0;
					end else begin
						pinCnt_reg <= pinCnt_reg + 1'b1;
					end
				end
				default: mode_reg <= MODE_SLEEP;
			endcase
		end
	end

	// Undervoltage or sleep resets the digital state
	assign logicClr = uvlo || (mode_reg == MODE_SLEEP);

	// AHB-Lite slave
	logic hreadyout_reg;
	logic hresp_reg;
	logic [31:0] hrdata_reg;
	logic wrPend_reg;
	mfm_reg_type wrSel_reg;
	logic [31:0] statusWord;
	logic [31:0] configWord;
	logic outEn_reg;
	logic ovBrakeEn_reg;
	logic softEn_reg;
	logic [1:0] regMode_reg;
	logic thSel_reg;
	logic ocSel_reg;
	logic clrStrobe_reg;
	logic [15:0] inrush_reg;
	logic [7:0] target_reg;
	logic addrPhase;

	assign addrPhase = hsel && hready && htrans[1];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
			hrdata_reg <= 32'h00000000;
			wrPend_reg <= 1'b0;
			wrSel_reg <= REG_NONE;
		end else if (clkEn) begin
			wrPend_reg <= addrPhase && hwrite;
			wrSel_reg <= regSel(haddr);
			if (addrPhase && !hwrite) begin
				unique case (regSel(haddr))
					REG_STATUS: hrdata_reg <= statusWord;
					REG_CONFIG: hrdata_reg <= configWord;
					REG_INRUSH: hrdata_reg <= {16'h0000, inrush_reg};
					REG_TARGET: hrdata_reg <= {24'h000000, target_reg};
					REG_NONE: hrdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// Configuration writes; brake enable survives sleep and undervoltage
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			outEn_reg <= OUT_EN_RESET;
			ovBrakeEn_reg <= OVP_EN_RESET;
			softEn_reg <= 1'b0;
			regMode_reg <= 2'h0;
			thSel_reg <= 1'b0;
			ocSel_reg <= 1'b0;
			clrStrobe_reg <= 1'b0;
			inrush_reg <= INRUSH_RESET;
			target_reg <= TARGET_RESET;
		end else if (clkEn) begin
			clrStrobe_reg <= 1'b0;
			if (logicClr) begin
				outEn_reg <= OUT_EN_RESET;
				softEn_reg <= 1'b0;
				regMode_reg <= 2'h0;
				thSel_reg <= 1'b0;
				ocSel_reg <= 1'b0;
				inrush_reg <= INRUSH_RESET;
				target_reg <= TARGET_RESET;
			end else if (wrPend_reg) begin
				unique case (wrSel_reg)
					REG_CONFIG: begin
						outEn_reg <= hwdata[CFG_OUTEN];
						ovBrakeEn_reg <= hwdata[CFG_OVP];
						softEn_reg <= hwdata[CFG_SOFT];
						regMode_reg <= hwdata[CFG_MODE+:2];
						thSel_reg <= hwdata[CFG_THSEL];
						ocSel_reg <= hwdata[CFG_OCSEL];
						clrStrobe_reg <= hwdata[CFG_CLR];
					end
					REG_INRUSH: inrush_reg <= hwdata[15:0];
					REG_TARGET: target_reg <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// Overcurrent deglitch, latch-off and retry
	logic [7:0] ocCnt_reg;
	logic [CNT_W-1:0] retryCnt_reg;
	logic ocHold_reg;
	logic ocFlag_reg;
	logic ocTrip;

	assign ocTrip = ocAny && !ocHold_reg && (ocCnt_reg == 8'(OCP_CYC - 1));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ocCnt_reg <= 8'h00;
		end else if (clkEn) begin
			if (logicClr || !ocAny || ocHold_reg || ocTrip) begin
				ocCnt_reg <= 8'h00;
			end else begin
				ocCnt_reg <= ocCnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ocHold_reg <= 1'b0;
			ocFlag_reg <= 1'b0;
			retryCnt_reg <= '0;
		end else if (clkEn) begin
			if (logicClr) begin
				ocHold_reg <= 1'b0;
				ocFlag_reg <= 1'b0;
			end else if (ocTrip) begin
				ocHold_reg <= 1'b1;
				ocFlag_reg <= 1'b1;
				retryCnt_reg <= CNT_W'(RETRY_CYCLES - 1);
			end else begin
				if (clrStrobe_reg) begin
					ocFlag_reg <= 1'b0;
				end
				if (ocHold_reg && ocSel_reg) begin
					if (retryCnt_reg == '0) begin
						ocHold_reg <= 1'b0;
					end else begin
						retryCnt_reg <= retryCnt_reg - 1'b1;
					end
				end else if (ocHold_reg && clrStrobe_reg) begin
					ocHold_reg <= 1'b0;
				end
			end
		end
	end

	// Thermal shutdown
	logic thHold_reg;
	logic thFlag_reg;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			thHold_reg <= 1'b0;
			thFlag_reg <= 1'b0;
		end else if (clkEn) begin
			if (logicClr) begin
				thHold_reg <= 1'b0;
				thFlag_reg <= 1'b0;
			end else if (hotS) begin
				thHold_reg <= 1'b1;
				thFlag_reg <= 1'b1;
			end else begin
				if (clrStrobe_reg) begin
					thFlag_reg <= 1'b0;
				end
				if (thHold_reg && (thSel_reg ? coolS : clrStrobe_reg)) begin
					thHold_reg <= 1'b0;
				end
			end
		end
	end

	// Power-on flag, fault pin, active mode
	logic powerOn_reg;
	logic faultOe_reg;
	logic active_reg;
	logic bridgeOk;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			powerOn_reg <= 1'b0;
			faultOe_reg <= 1'b0;
			active_reg <= 1'b0;
		end else if (clkEn) begin
			if (uvlo) begin
				powerOn_reg <= 1'b0;
			end else if (clrStrobe_reg) begin
				powerOn_reg <= 1'b1;
			end
			faultOe_reg <= uvlo || ocHold_reg || thHold_reg;
			active_reg <= (mode_reg == MODE_ON) && outEn_reg && !uvlo;
		end
	end

	assign bridgeOk = active_reg && !logicClr && !ocHold_reg && !thHold_reg;

	// Start, soft ramp and stall blanking
	mfm_ramp_type phase_reg;
	logic start_reg;
	logic [23:0] code_reg;
	logic dir_reg;
	logic [15:0] subTick_reg;
	logic [7:0] ramp_reg;
	logic stallFlag_reg;
	logic softOn;
	logic runReq;
	logic stopReq;
	logic stepNow;
	logic windowDone;

	assign softOn = softEn_reg && regMode_reg[1];
	assign runReq = ctrlS[0] ^ ctrlS[1];
	assign stopReq = !runReq || (ctrlS[1] != dir_reg) ||
		(softOn && target_reg == 8'h00);
	assign stepNow = tIf.tick && (subTick_reg == inrush_reg - 1'b1);
	assign windowDone = !start_reg && !tIf.busy;
	assign tIf.clkEn = clkEn;
	assign tIf.clear = logicClr;
	assign tIf.start = start_reg;
	assign tIf.code = code_reg;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			phase_reg <= RAMP_IDLE;
			start_reg <= 1'b0;
			code_reg <= 24'h000000;
			dir_reg <= 1'b0;
			subTick_reg <= 16'h0000;
			ramp_reg <= 8'h00;
		end else if (clkEn) begin
			start_reg <= 1'b0;
			if (tIf.tick) begin
				subTick_reg <= stepNow ? 16'h0000 : subTick_reg + 1'b1;
			end
			if (!bridgeOk) begin
				phase_reg <= RAMP_IDLE;
				ramp_reg <= 8'h00;
			end else begin
				unique case (phase_reg)
					RAMP_IDLE: begin
						if (runReq) begin
							start_reg <= 1'b1;
							code_reg <= softOn ? 24'(inrush_reg) * 24'(target_reg)
								: {8'h00, inrush_reg};
							dir_reg <= ctrlS[1];
							subTick_reg <= 16'h0000;
							ramp_reg <= softOn ? 8'h00 : target_reg;
							phase_reg <= RAMP_UP;
						end
					end
					RAMP_UP, RAMP_RUN: begin
						if (stopReq && softOn && ramp_reg != 8'h00) begin
							start_reg <= 1'b1;
							code_reg <= 24'(inrush_reg) * 24'(ramp_reg);
							subTick_reg <= 16'h0000;
							phase_reg <= RAMP_DOWN;
						end else if (stopReq) begin
							ramp_reg <= 8'h00;
							phase_reg <= RAMP_IDLE;
						end else if (phase_reg == RAMP_UP && windowDone) begin
							ramp_reg <= target_reg;
							phase_reg <= RAMP_RUN;
						end else if (phase_reg == RAMP_UP && stepNow &&
							ramp_reg != target_reg) begin
							ramp_reg <= ramp_reg + 1'b1;
						end
					end
					RAMP_DOWN: begin
						if (windowDone) begin
							ramp_reg <= 8'h00;
							phase_reg <= RAMP_IDLE;
						end else if (stepNow && ramp_reg != 8'h00) begin
							ramp_reg <= ramp_reg - 1'b1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stallFlag_reg <= 1'b0;
		end else if (clkEn) begin
			if (logicClr) begin
				stallFlag_reg <= 1'b0;
			end else if (stallS && phase_reg != RAMP_IDLE && !tIf.busy &&
				!start_reg) begin
				stallFlag_reg <= 1'b1;
			end else if (clrStrobe_reg) begin
				stallFlag_reg <= 1'b0;
			end
		end
	end

	mfm_inrush_timer #(
		.BASE_CYCLES(INRUSH_BASE_CYCLES),
		.STEP_CYCLES(INRUSH_STEP_CYC)
	) uTimer (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.tIf(tIf)
	);

	// Bridge gates and overvoltage braking
	logic [1:0] hsGate_reg;
	logic [1:0] lsGate_reg;
	logic ovpBrake_reg;
	logic sleepOcOff_reg;
	logic driving;
	logic brakeIn;
	logic ovpCond;

	assign driving = bridgeOk && phase_reg != RAMP_IDLE;
	assign brakeIn = bridgeOk && ctrlS == 2'h3;
	assign ovpCond = ovBrakeEn_reg && ovS && !uvlo && !sleepOcOff_reg &&
		(mode_reg == MODE_SLEEP || !(driving || brakeIn));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			hsGate_reg <= 2'h0;
			lsGate_reg <= 2'h0;
			ovpBrake_reg <= 1'b0;
		end else if (clkEn) begin
			ovpBrake_reg <= ovpCond;
			hsGate_reg <= driving ? (dir_reg ? 2'h2 : 2'h1) : 2'h0;
			if (brakeIn || ovpCond) begin
				lsGate_reg <= 2'h3;
			end else begin
				lsGate_reg <= driving ? (dir_reg ? 2'h1 : 2'h2) : 2'h0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sleepOcOff_reg <= 1'b0;
		end else if (clkEn) begin
			if (!ovS || mode_reg != MODE_SLEEP) begin
				sleepOcOff_reg <= 1'b0;
			end else if (lsGate_reg != 2'h0 && sleepOcS) begin
				sleepOcOff_reg <= 1'b1;
			end
		end
	end

	always_comb begin
		statusWord = 32'h00000000;
		statusWord[ST_POWER] = powerOn_reg;
		statusWord[ST_THERM] = thFlag_reg;
		statusWord[ST_OVP] = ovpBrake_reg;
		statusWord[ST_OC] = ocFlag_reg;
		statusWord[ST_STALL] = stallFlag_reg;
		statusWord[ST_FAULT] = faultOe_reg;
		statusWord[ST_SLEEP] = (mode_reg == MODE_SLEEP);
		statusWord[ST_ACTIVE] = active_reg;
		configWord = 32'h00000000;
		configWord[CFG_OUTEN] = outEn_reg;
		configWord[CFG_OVP] = ovBrakeEn_reg;
		configWord[CFG_SOFT] = softEn_reg;
		configWord[CFG_MODE+:2] = regMode_reg;
		configWord[CFG_THSEL] = thSel_reg;
		configWord[CFG_OCSEL] = ocSel_reg;
	end

	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;
	assign hrdata = hrdata_reg;
	assign hsGate = hsGate_reg;
	assign lsGate = lsGate_reg;
	assign faultOutN = hresp_reg;
	assign faultOutNOe = faultOe_reg;
	assign activeMode = active_reg;
	assign stallDetect = stallFlag_reg;
	assign rampLevel = ramp_reg;

	sequence ocTripSeq;
		ocTrip && clkEn && !logicClr ##1 clkEn;
	endsequence

	a_oc_trip_shutdown: assert property (ocTripSeq |->
		ocHold_reg && ocFlag_reg ##1 faultOutNOe)
		else $error("overcurrent trip did not shut down");
	a_oc_latch_hold: assert property (ocHold_reg && !ocSel_reg &&
		!clrStrobe_reg && !logicClr && clkEn |=> ocHold_reg)
		else $error("latched overcurrent released without clear");
	a_oc_retry_end: assert property (ocHold_reg && ocSel_reg &&
		retryCnt_reg == '0 && !logicClr && clkEn |=> !ocHold_reg)
		else $error("retry did not release after retry time");
	a_stall_blanked: assert property (tIf.busy && clkEn &&
		!stallFlag_reg |=> !stallFlag_reg)
		else $error("stall reported inside inrush window");
	a_therm_auto: assert property (thHold_reg && thSel_reg && coolS &&
		!hotS && !logicClr && clkEn |=> !thHold_reg && thFlag_reg)
		else $error("thermal auto recovery wrong");
	a_uvlo_reset: assert property (uvlo && clkEn |=>
		!ocHold_reg && !powerOn_reg && faultOutNOe && !active_reg)
		else $error("undervoltage did not reset logic");
	a_power_flag: assert property (clrStrobe_reg && !uvlo && clkEn
		|=> powerOn_reg)
		else $error("clear did not set power-on flag");
	a_ovp_brake: assert property (ovpCond && clkEn |=>
		lsGate == 2'h3 && hsGate == 2'h0)
		else $error("overvoltage brake not applied");
	a_sleep_hiz: assert property (mode_reg == MODE_SLEEP && clkEn
		|=> hsGate == 2'h0)
		else $error("high side on in sleep");
	a_active_gate: assert property (!outEn_reg && clkEn |=>
		!activeMode)
		else $error("active without output enable");
endmodule
